// ---- dump_sink.sv ----
// model: host memory sink that takes dump words
`timescale 1ns/10ps
module dump_sink (
	input wire logic mclk,
	input wire logic slow,
	input wire logic dump_valid,
	input wire logic [7:0] dump_offset,
	input wire logic [stat_pkg::cnt_width-1:0] dump_data,
	output logic dump_ready
);
	import stat_pkg::*;
	logic [cnt_width-1:0] mem [num_counters];
	int words;
	logic [1:0] ph;
	initial
	begin
		dump_ready = 1'h0;
		words = 0;
		ph = 2'h0;
	end
	always @(posedge mclk)
	begin
		if (dump_valid && dump_ready)
		begin
			mem[dump_offset[5:2]] = dump_data;
			words++;
		end
		ph <= ph + 2'h1;
		dump_ready <= #1 !slow || ph == 2'h3;
	end
endmodule : dump_sink

// ---- frame_statistics_counters.sv ----
// top: per-event frame statistics counters with dump sequencer
`timescale 1ns/10ps
module frame_statistics_counters (
	mclk,
	sys_rst,
	tx_report,
	rx_report,
	command_unit_command_field,
	dump_ready,
	dump_valid,
	dump_offset,
	dump_data,
	dump_busy,
	dump_complete
);
	import stat_pkg::*;
	input wire logic mclk;
	input wire logic sys_rst;
	input wire stat_pkg::tx_report_type tx_report;
	input wire stat_pkg::rx_report_type rx_report;
	input wire stat_pkg::dump_cmd_type command_unit_command_field;
	input wire logic dump_ready;
	output logic dump_valid;
	output logic [7:0] dump_offset;
	output logic [stat_pkg::cnt_width-1:0] dump_data;
	output logic dump_busy;
	output logic dump_complete;

	// ==========================================================
	// event decode
	logic [num_counters-1:0] inc;
	logic [coll_width-1:0] amount [num_counters];
	logic [num_counters-1:0] clear;
	logic [cnt_width-1:0] value [num_counters];
	logic tx_ok;
	logic rx_fcs;

	always_comb
	begin
		inc = '0;
		for (int i = 0; i < num_counters; i++)
		begin
			amount[i] = coll_one;
		end
		// single, multiple and lost-carrier count good frames only
		// only at frame completion
		tx_ok = tx_report.done && tx_report.good;
		inc[idx_tx_good] = tx_ok;
		inc[idx_max_coll] = tx_report.done && tx_report.max_collision_limit_error;
		inc[idx_late_coll] = tx_report.done && tx_report.late_collision_error;
		inc[idx_underrun] = tx_report.done && (tx_report.underruns != 4'h0);
		amount[idx_underrun] = {1'b0, tx_report.underruns};
		inc[idx_lost_crs] = tx_ok && tx_report.lost_carrier;
		inc[idx_deferred] = tx_report.done && tx_report.deferred;
		inc[idx_single_coll] = tx_ok && (tx_report.collisions == coll_one);
		inc[idx_multi_coll] = tx_ok && (tx_report.collisions > coll_one);
		inc[idx_total_coll] = tx_report.done && (tx_report.collisions != coll_zero);
		amount[idx_total_coll] = tx_report.collisions;
		inc[idx_rx_good] = rx_report.done && rx_report.stored_ok;
		rx_fcs = rx_report.done && rx_report.crc_error && !rx_report.short_frame;
		inc[idx_rx_crc] = rx_fcs && !rx_report.misaligned;
		inc[idx_rx_align] = rx_fcs && rx_report.misaligned;
	end

	// ==========================================================
	// counters
	// one wrapping counter per dump word, in offset order
	genvar g;
	generate
		for (g = 0; g < num_counters; g++)
		begin : gen_cnt
			stat_counter u_cnt (
				.mclk(mclk),
				.sys_rst(sys_rst),
				.inc(inc[g]),
				.amount(amount[g]),
				.clear(clear[g]),
				.value(value[g])
			);
		end
	endgenerate

	// ==========================================================
	// dump sequencer
	dump_state_type state_q;
	dump_state_type state_d;
	logic [idx_width-1:0] idx_q;
	logic [idx_width-1:0] idx_d;
	logic reset_mode_q;
	logic reset_mode_d;
	logic dump_valid_q;
	logic dump_valid_d;
	logic [7:0] dump_offset_q;
	logic [7:0] dump_offset_d;
	logic [cnt_width-1:0] dump_data_q;
	logic [cnt_width-1:0] dump_data_d;
	logic dump_complete_q;
	logic dump_complete_d;
	logic accept;
	logic last_word;
	logic dump_busy_q;
	logic dump_busy_d;

	always_comb
	begin
		state_d = state_q;
		idx_d = idx_q;
		reset_mode_d = reset_mode_q;
		dump_valid_d = dump_valid_q;
		dump_offset_d = dump_offset_q;
		dump_data_d = dump_data_q;
		dump_complete_d = 1'b0;
		clear = '0;
		accept = dump_valid_q && dump_ready;
		last_word = (dump_offset_q == 8'(idx_last) * offset_step);
		case (state_q)
			st_idle:
			begin
				// command starts dump
				// code 3 runs as a plain dump; a command in the completion cycle is ignored
				if (command_unit_command_field != dump_none && !dump_busy_q)
				begin
					reset_mode_d = (command_unit_command_field == dump_and_reset);
					idx_d = idx_tx_good;
					state_d = st_dump;
				end
			end
			st_dump:
			begin
				if (!dump_valid_q || accept)
				begin
					if (accept && last_word)
					begin
						dump_valid_d = 1'b0;
						state_d = st_done;
					end
					else
					begin
						// snapshot then clear
						// the counter adds an event of this same edge after clearing
						// the next word loads on the accepting edge, so words run back to back
						dump_valid_d = 1'b1;
						dump_data_d = value[idx_q];
						dump_offset_d = 8'(idx_q) * offset_step;
						clear[idx_q] = reset_mode_q;
						idx_d = idx_q + 4'h1;
					end
				end
			end
			st_done:
			begin
				dump_complete_d = 1'b1;
				state_d = st_idle;
			end
			default:
			begin
				state_d = st_idle;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_q <= st_idle;
			idx_q <= idx_tx_good;
			reset_mode_q <= 1'b0;
			dump_valid_q <= 1'b0;
			dump_offset_q <= 8'h00;
			dump_data_q <= cnt_reset;
			dump_complete_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			idx_q <= idx_d;
			reset_mode_q <= reset_mode_d;
			dump_valid_q <= dump_valid_d;
			dump_offset_q <= dump_offset_d;
			dump_data_q <= dump_data_d;
			dump_complete_q <= dump_complete_d;
		end
	end

	// ==========================================================
	// busy flag
	// busy also covers the completion pulse, so a new run
	// cannot start while the previous one is still reporting
	always_comb
	begin
		dump_busy_d = (state_d != st_idle) || dump_complete_d;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			dump_busy_q <= 1'b0;
		else
			dump_busy_q <= dump_busy_d;
	end

	assign dump_valid = dump_valid_q;
	assign dump_offset = dump_offset_q;
	assign dump_data = dump_data_q;
	assign dump_busy = dump_busy_q;
	assign dump_complete = dump_complete_q;
endmodule : frame_statistics_counters

// ---- stat_counter.sv ----
// single wrapping statistics counter with snapshot-and-clear
`timescale 1ns/10ps
module stat_counter (
	mclk,
	sys_rst,
	inc,
	amount,
	clear,
	value
);
	import stat_pkg::*;
	input wire logic mclk;
	input wire logic sys_rst;
	input wire logic inc;
	input wire logic [stat_pkg::coll_width-1:0] amount;
	input wire logic clear;
	output logic [stat_pkg::cnt_width-1:0] value;

	logic [cnt_width-1:0] value_q;
	logic [cnt_width-1:0] value_d;

	always_comb
	begin
		value_d = value_q;
		if (clear)
			value_d = cnt_reset;
		if (inc)
			value_d = (clear ? cnt_reset : value_q) + {{(cnt_width-coll_width){1'b0}}, amount};
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			value_q <= cnt_reset;
		else
			value_q <= value_d;
	end

	assign value = value_q;
endmodule : stat_counter

// ---- stat_pkg.sv ----
// package: constants and carriers for the frame statistics counters
// Notes on behaviour
// - counters change only when a transmitted or received frame has finished or dump-and-reset clears them
// - dump or dump-and-reset command from command unit reports all counters
// - transmit good frames, offset 0, counts only after link transmission ends
// - offset 4 counts frames abandoned at the maximum collision limit
// - offset 8 counts frames dropped for a collision after slot time
// - offset 12 counts underruns; may count several times per frame
// - offset 16 counts frames sent while carrier sense was lost
// - offset 20 counts frames deferred by existing link activity
// - offset 24 counts frames sent after exactly one collision
// - offset 28 counts frames sent after two or more collisions
// - offset 40 counts octet-aligned received frames with a checksum error
// - offset 44 counts misaligned received frames with a checksum error
// - at most one of checksum, alignment, short-frame counts per received frame
// - checksum and alignment counts update whatever the receive unit state
// - counters are 32 bits and wrap from all ones to zero
// - every applicable counter is updated when a frame has several errors
package stat_pkg;
	localparam int cnt_width = 32;
	localparam int num_counters = 12;
	localparam int idx_width = 4;
	localparam int coll_width = 5;
	localparam logic [cnt_width-1:0] cnt_reset = 32'h0000_0000;
	localparam logic [cnt_width-1:0] cnt_one = 32'h0000_0001;
	// counter indices; the dump offset of counter i is 4*i
	localparam logic [idx_width-1:0] idx_tx_good = 4'h0;
	localparam logic [idx_width-1:0] idx_max_coll = 4'h1;
	localparam logic [idx_width-1:0] idx_late_coll = 4'h2;
	localparam logic [idx_width-1:0] idx_underrun = 4'h3;
	localparam logic [idx_width-1:0] idx_lost_crs = 4'h4;
	localparam logic [idx_width-1:0] idx_deferred = 4'h5;
	localparam logic [idx_width-1:0] idx_single_coll = 4'h6;
	localparam logic [idx_width-1:0] idx_multi_coll = 4'h7;
	localparam logic [idx_width-1:0] idx_total_coll = 4'h8;
	localparam logic [idx_width-1:0] idx_rx_good = 4'h9;
	localparam logic [idx_width-1:0] idx_rx_crc = 4'hA;
	localparam logic [idx_width-1:0] idx_rx_align = 4'hB;
	localparam logic [idx_width-1:0] idx_last = 4'hB;
	localparam logic [7:0] offset_step = 8'h04;
	localparam logic [coll_width-1:0] coll_zero = 5'h00;
	localparam logic [coll_width-1:0] coll_one = 5'h01;
	localparam logic [3:0] underrun_step_max = 4'hF;

	// transmit completion report, valid for one cycle
	typedef struct packed {
		logic done;
		logic good;
		logic max_collision_limit_error;
		logic late_collision_error;
		logic lost_carrier;
		logic deferred;
		logic [coll_width-1:0] collisions;
		logic [3:0] underruns;
	} tx_report_type;

	// receive completion report, valid for one cycle
	typedef struct packed {
		logic done;
		logic stored_ok;
		logic crc_error;
		logic misaligned;
		logic short_frame;
	} rx_report_type;

	// command unit dump request
	typedef enum logic [1:0] {
		dump_none = 2'h0,
		dump_only = 2'h1,
		dump_and_reset = 2'h2
	} dump_cmd_type;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_dump = 3'b010,
		st_done = 3'b100
	} dump_state_type;
endpackage : stat_pkg

// ---- stat_props.sv ----
// checker: dump sequencing properties of the statistics block
`timescale 1ns/10ps
module stat_props (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire stat_pkg::dump_cmd_type command_unit_command_field,
	input wire logic dump_ready,
	input wire logic dump_valid,
	input wire logic [7:0] dump_offset,
	input wire logic [stat_pkg::cnt_width-1:0] dump_data,
	input wire logic dump_busy,
	input wire logic dump_complete
);
	import stat_pkg::*;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	logic go;
	logic take;
	assign go = !dump_busy && command_unit_command_field != dump_none;
	assign take = dump_valid && dump_ready;
	sequence s_last;
		take && dump_offset == 8'h2C;
	endsequence
	sequence s_finish;
		!dump_valid ##1 dump_complete ##1 !dump_complete;
	endsequence
	// ==========
	// dump run
	a_busy_on_cmd: assert property (go |=> dump_busy) else $error("busy late");
	a_first_word: assert property (go |-> ##2 dump_valid && dump_offset == 8'h00)
		else $error("first word wrong");
	a_word_holds: assert property (dump_valid && !dump_ready |=>
		dump_valid && $stable(dump_offset) && $stable(dump_data)) else $error("word moved");
	a_offset_step: assert property (take && dump_offset != 8'h2C |=>
		dump_valid && dump_offset == $past(dump_offset) + 8'h04) else $error("bad step");
	a_run_finish: assert property (s_last |=> s_finish) else $error("bad finish");
	a_idle_after: assert property (dump_complete |=> !dump_busy) else $error("still busy");
	a_offset_align: assert property (dump_valid |->
		dump_offset <= 8'h2C && dump_offset[1:0] == 2'h0) else $error("bad offset");
	a_quiet_idle: assert property (!dump_busy |->
		!dump_valid && !dump_complete) else $error("idle output");
endmodule : stat_props

bind frame_statistics_counters stat_props u_props (.mclk(mclk), .sys_rst(sys_rst),
	.command_unit_command_field(command_unit_command_field), .dump_ready(dump_ready),
	.dump_valid(dump_valid), .dump_offset(dump_offset), .dump_data(dump_data),
	.dump_busy(dump_busy), .dump_complete(dump_complete));

// ---- tb_top.sv ----
// testbench: scenarios for the frame statistics counters
`timescale 1ns/10ps
module tb_top;
	import stat_pkg::*;
	logic mclk;
	logic sys_rst;
	tx_report_type tx_report;
	rx_report_type rx_report;
	dump_cmd_type cmd;
	logic dump_ready;
	logic dump_valid;
	logic [7:0] dump_offset;
	logic [cnt_width-1:0] dump_data;
	logic dump_busy;
	logic dump_complete;
	logic slow;
	logic [cnt_width-1:0] exp_cnt [num_counters];
	int errors;
	int total_checks;
	frame_statistics_counters dut (.mclk(mclk), .sys_rst(sys_rst), .tx_report(tx_report),
		.rx_report(rx_report), .command_unit_command_field(cmd), .dump_ready(dump_ready),
		.dump_valid(dump_valid), .dump_offset(dump_offset), .dump_data(dump_data),
		.dump_busy(dump_busy), .dump_complete(dump_complete));
	dump_sink sink (.mclk(mclk), .slow(slow), .dump_valid(dump_valid),
		.dump_offset(dump_offset), .dump_data(dump_data), .dump_ready(dump_ready));
	initial
	begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	task automatic step;
		@(posedge mclk);
		#1;
	endtask : step
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	task automatic check_word(input logic [cnt_width-1:0] got, input logic [cnt_width-1:0] want);
		total_checks++;
		if (got !== want)
		begin
			errors++;
			$display("[FAIL] %0t word %h want %h", $time, got, want);
		end
	endtask : check_word
	// ==========
	// frame reports with expected counts
	task automatic send_tx(input tx_report_type t);
		tx_report = t;
		step();
		tx_report = '0;
		step();
		if (t.done)
		begin
			exp_cnt[0] += 32'(t.good);
			exp_cnt[1] += 32'(t.max_collision_limit_error);
			exp_cnt[2] += 32'(t.late_collision_error);
			exp_cnt[3] += 32'(t.underruns);
			exp_cnt[4] += 32'(t.good && t.lost_carrier);
			exp_cnt[5] += 32'(t.deferred);
			exp_cnt[6] += 32'(t.good && t.collisions == 5'h01);
			exp_cnt[7] += 32'(t.good && t.collisions > 5'h01);
			exp_cnt[8] += 32'(t.collisions);
		end
	endtask : send_tx
	task automatic send_rx(input rx_report_type r);
		rx_report = r;
		step();
		rx_report = '0;
		step();
		if (r.done)
		begin
			exp_cnt[9] += 32'(r.stored_ok);
			exp_cnt[10] += 32'(r.crc_error && !r.misaligned && !r.short_frame);
			exp_cnt[11] += 32'(r.crc_error && r.misaligned && !r.short_frame);
		end
	endtask : send_rx
	// event t lands on the edge that snapshots counter 0 and, for dump_and_reset, clears it
	task automatic run_dump(input dump_cmd_type c, input tx_report_type t);
		logic [cnt_width-1:0] snap [num_counters];
		int n;
		snap = exp_cnt;
		if (c == dump_and_reset)
			exp_cnt = '{default: '0};
		sink.words = 0;
		cmd = c;
		step();
		cmd = dump_none;
		send_tx(t);
		for (n = 0; n < 300 && dump_complete !== 1'h1; n++)
			step();
		if (n == 300)
		begin
			errors++;
			$display("[FAIL] %0t dump never completed", $time);
			wrap_up();
		end
		check_word(32'(sink.words), 32'h0000000C);
		for (n = 0; n < num_counters; n++)
			check_word(sink.mem[n], snap[n]);
		step();
	endtask : run_dump
	// ==========
	// scenarios
	task automatic t_tx;
		send_tx('{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 5'h03, 4'h2});
		send_tx('{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 5'h00, 4'h0});
		send_tx('{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 5'h10, 4'h0});
		send_tx('{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 5'h01, 4'h0});
		send_tx('{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 5'h00, 4'h3});
		send_tx('{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 5'h01, 4'h0});
		send_tx('{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 5'h02, 4'h0});
		run_dump(dump_cmd_type'(2'h3), '0);
	endtask : t_tx
	task automatic t_rx;
		send_rx('{1'h1, 1'h1, 1'h0, 1'h0, 1'h0});
		send_rx('{1'h1, 1'h0, 1'h1, 1'h0, 1'h0});
		send_rx('{1'h1, 1'h0, 1'h1, 1'h1, 1'h0});
		send_rx('{1'h1, 1'h0, 1'h1, 1'h1, 1'h1});
		send_rx('{1'h1, 1'h0, 1'h1, 1'h0, 1'h1});
		slow = 1'h0;
		run_dump(dump_only, '0);
	endtask : t_rx
	task automatic t_clear;
		run_dump(dump_and_reset, '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 5'h00, 4'h0});
		slow = 1'h1;
		run_dump(dump_only, '0);
	endtask : t_clear
	initial
	begin
		sys_rst = 1'h1;
		tx_report = '0;
		rx_report = '0;
		cmd = dump_none;
		slow = 1'h1;
		errors = 0;
		total_checks = 0;
		exp_cnt = '{default: '0};
		repeat (16) step();
		sys_rst = 1'h0;
		run_dump(dump_only, '0);
		t_tx();
		t_rx();
		t_clear();
		wrap_up();
	end
endmodule : tb_top
